/* rtl/dpg_pkg.sv */
// Shared constants and types for the playback gain and limiter block.
// Assumes one 40 MHz clock and samples from same-clock interface logic.
package dpg_pkg;

    localparam int SAMPLE_W = 24;
    localparam int REG_W    = 9;

    typedef struct packed {
        logic                valid;
        logic [SAMPLE_W-1:0] data;
    } dpg_sample_type;

    typedef enum logic [1:0] {
        LIM_HOLD   = 2'b00,
        LIM_ATTACK = 2'b01,
        LIM_DECAY  = 2'b10
    } dpg_lim_state_type;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER3   = 8'h03;
    localparam logic [7:0] IDX_PB_CTRL  = 8'h0a;
    localparam logic [7:0] IDX_PB_VOL   = 8'h0b;
    localparam logic [7:0] IDX_LIM_CTL1 = 8'h18;
    localparam logic [7:0] IDX_LIM_CTL2 = 8'h19;
    localparam logic [7:0] IDX_STATUS   = 8'h1f;

    // Field positions
    localparam int POS_CONV_EN    = 0;
    localparam int POS_POL_INV    = 0;
    localparam int POS_ZMUTE_EN   = 2;
    localparam int POS_SOFT_MUTE  = 6;
    localparam int POS_LIM_EN     = 8;
    localparam int POS_DCY_LSB    = 4;
    localparam int POS_ATK_LSB    = 0;
    localparam int POS_LVL_LSB    = 4;
    localparam int POS_BOOST_LSB  = 0;

    // Reset values
    localparam logic [REG_W-1:0] RST_POWER3   = 9'h000;
    localparam logic [REG_W-1:0] RST_PB_CTRL  = 9'h000;
    localparam logic [REG_W-1:0] RST_PB_VOL   = 9'h0ff;
    localparam logic [REG_W-1:0] RST_LIM_CTL1 = 9'h032;
    localparam logic [REG_W-1:0] RST_LIM_CTL2 = 9'h000;

    // Gain arithmetic works in half-dB units
    localparam logic [9:0] HEADROOM_HDB   = 10'h018;
    localparam logic [3:0] BOOST_MAX_CODE = 4'hc;
    localparam logic [3:0] RATE_MAX_CODE  = 4'hb;
    localparam logic [2:0] LVL_MAX_CODE   = 3'h5;
    localparam logic [7:0] LIM_ATT_MAX    = 8'hff;
    localparam logic [7:0] SM_ATT_MAX     = 8'hff;
    localparam int         STEPS_PER_6DB  = 12;
    localparam int         ZERO_RUN_LEN   = 1024;

    // Rate timing, counted in samples so it scales with the sample rate
    localparam longint REF_RATE_HZ   = 44100;
    localparam longint ATK_BASE_NS   = 94000;
    localparam longint DCY_BASE_NS   = 750000;
    localparam longint ACC_SCALE     = 16;
    localparam logic [21:0] ACC_ADD  =
        22'(STEPS_PER_6DB * ACC_SCALE);
    localparam logic [21:0] ATK_BASE =
        22'(ATK_BASE_NS * REF_RATE_HZ * ACC_SCALE / 64'd1000000000);
    localparam logic [21:0] DCY_BASE =
        22'(DCY_BASE_NS * REF_RATE_HZ * ACC_SCALE / 64'd1000000000);

endpackage : dpg_pkg

/* rtl/dpg_playback.sv */
// Playback gain path: volume, soft mute, boost, peak limiter, polarity and
// zero-run mute, with an APB register slave.
// Assumes samples arrive as one-cycle valid pulses on the same clock.
`timescale 1ns/1ps
// Behaviour
// - Path processes samples only while converter enable bit 0 is set; resets off.
// - Volume code X gives 0.5*(X-255) dB; code 0 mutes fully.
// - Volume field bits 7:0 resets to all ones, unity gain.
// - Soft mute bit 6 ramps the volume down gradually by up to 127.5 dB.
// - Clearing soft mute ramps gain back up to the programmed volume.
// - Soft mute resets cleared; it must stay cleared for playback.
// - Output non-inverted after reset; polarity bit inverts the output.
// - With zero-run mute enabled, mute after 1024 consecutive zero samples.
// - First non-zero sample releases that mute immediately.
// - Zero-run mute enable is bit 2, reset 0.
// - No boost: samples below upper threshold pass unchanged.
// - Above upper threshold, gain falls at attack rate until below it.
// - Lower threshold sits 1 dB below upper, giving hysteresis.
// - Below lower threshold, gain rises at decay rate to 0 dB.
// - Upper threshold 0.5 dB above level, lower 0.5 dB below.
// - Boost adds 0 to +12 dB in 1 dB steps below threshold.
// - Boost still applies as fixed gain with the limiter disabled.
// - Limiter enable is bit 8 of limiter control one, reset 0.
// - Decay code doubles from 750 us per 6 dB; codes 11-15 give 1.536 s.
// - Threshold code: -1 dB at 0, 1 dB lower per code, 5-7 give -6 dB.
// - Boost code 0 is 0 dB, each increment adds 1 dB; 12-15 give +12 dB.
module dpg_playback
    import dpg_pkg::*;
(
    input  wire logic           CLK_I,
    input  wire logic           RST_N_I,
    input  wire logic           PSEL_I,
    input  wire logic           PENABLE_I,
    input  wire logic           PWRITE_I,
    input  wire logic [9:0]     PADDR_I,
    input  wire logic [31:0]    PWDATA_I,
    output logic      [31:0]    PRDATA_O,
    output logic                PREADY_O,
    output logic                PSLVERR_O,
    input  wire dpg_sample_type SAMPLE_I,
    output dpg_sample_type      SAMPLE_O,
    output logic                ZERO_MUTE_O
);

    // Mantissa of 10^(-k/40), one half-dB step per k, scaled by 16384
    function automatic logic [14:0] mant(input logic [3:0] k);
        case (k)
            4'h0:    mant = 15'h4000;
            4'h1:    mant = 15'h3c6b;
            4'h2:    mant = 15'h390a;
            4'h3:    mant = 15'h35d9;
            4'h4:    mant = 15'h32d6;
            4'h5:    mant = 15'h2ffe;
            4'h6:    mant = 15'h2d4f;
            4'h7:    mant = 15'h2ac6;
            4'h8:    mant = 15'h2862;
            4'h9:    mant = 15'h261f;
            4'ha:    mant = 15'h23fd;
            default: mant = 15'h21fa;
        endcase
    endfunction : mant

    // Linear magnitude of full scale attenuated by att half-dB steps
    function automatic logic [23:0] thr_of(input logic [4:0] att);
        logic [3:0]  k;
        logic [1:0]  sh;
        logic [23:0] base;
        k    = 4'(att % 5'd12);
        sh   = 2'(att / 5'd12);
        base = {mant(k), 9'h000};
        thr_of = base >> sh;
    endfunction : thr_of

    logic [REG_W-1:0] power3_q;
    logic [REG_W-1:0] pb_ctrl_q;
    logic [REG_W-1:0] pb_vol_q;
    logic [REG_W-1:0] lim1_q;
    logic [REG_W-1:0] lim2_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [31:0]      prdata_q;

    logic [7:0]        sm_att_q;
    logic [7:0]        lim_att_q;
    logic [21:0]       acc_q;
    dpg_lim_state_type lim_state_q;
    logic [10:0]       zero_cnt_q;
    logic              zero_mute_q;
    dpg_sample_type    out_q;

    // Register fields
    wire       conv_en   = power3_q[POS_CONV_EN];
    wire       soft_mute = pb_ctrl_q[POS_SOFT_MUTE];
    wire       pol_inv   = pb_ctrl_q[POS_POL_INV];
    wire       zmute_en  = pb_ctrl_q[POS_ZMUTE_EN];
    wire [7:0] vol_code  = pb_vol_q[7:0];
    wire       lim_en    = lim1_q[POS_LIM_EN];
    wire [3:0] dcy_code  = lim1_q[POS_DCY_LSB +: 4];
    wire [3:0] atk_code  = lim1_q[POS_ATK_LSB +: 4];
    wire [2:0] lvl_code  = lim2_q[POS_LVL_LSB +: 3];
    wire [3:0] bst_code  = lim2_q[POS_BOOST_LSB +: 4];

    // APB decode
    wire        acc_phase = PSEL_I & PENABLE_I;
    wire        take      = acc_phase & pready_q;
    wire [7:0]  reg_idx   = PADDR_I[9:2];
    wire        hit_pw3   = reg_idx == IDX_POWER3;
    wire        hit_ctl   = reg_idx == IDX_PB_CTRL;
    wire        hit_vol   = reg_idx == IDX_PB_VOL;
    wire        hit_l1    = reg_idx == IDX_LIM_CTL1;
    wire        hit_l2    = reg_idx == IDX_LIM_CTL2;
    wire        hit_st    = reg_idx == IDX_STATUS;
    wire        mapped    = (hit_pw3 | hit_ctl | hit_vol | hit_l1 | hit_l2
                             | hit_st) & (PADDR_I[1:0] == 2'b00);
    wire        wr_ok     = take & PWRITE_I & mapped;
    wire [31:0] status    = {8'h00, sm_att_q, lim_att_q, 4'h0,
                             2'(lim_state_q), |lim_att_q, zero_mute_q};
    wire [31:0] rd_mux    =
        !mapped ? 32'h0000_0000 :
        hit_pw3 ? {23'h00_0000, power3_q} :
        hit_ctl ? {23'h00_0000, pb_ctrl_q} :
        hit_vol ? {23'h00_0000, pb_vol_q} :
        hit_l1  ? {23'h00_0000, lim1_q} :
        hit_l2  ? {23'h00_0000, lim2_q} : status;

    // Codes clamped to their tables
    wire [3:0] bst_c = (bst_code > BOOST_MAX_CODE) ? BOOST_MAX_CODE
                                                   : bst_code;
    wire [3:0] dcy_c = (dcy_code > RATE_MAX_CODE) ? RATE_MAX_CODE
                                                  : dcy_code;
    wire [3:0] atk_c = (atk_code > RATE_MAX_CODE) ? RATE_MAX_CODE
                                                  : atk_code;
    wire [2:0] lvl_c = (lvl_code > LVL_MAX_CODE) ? LVL_MAX_CODE
                                                 : lvl_code;
    wire [21:0] atk_period = ATK_BASE << atk_c;
    wire [21:0] dcy_period = DCY_BASE << dcy_c;

    // Thresholds: level is -(1+code) dB; bounds are 0.5 dB either side
    wire [4:0]  up_att = {1'b0, lvl_c, 1'b1};
    wire [4:0]  lo_att = up_att + 5'd2;
    wire [23:0] thr_up = thr_of(up_att);
    wire [23:0] thr_lo = thr_of(lo_att);

    // Total attenuation from +12 dB headroom, in half-dB units
    wire [9:0] vol_att  = 10'(8'hff - vol_code);
    wire [9:0] lim_att  = lim_en ? {2'b00, lim_att_q} : 10'h000;
    wire [9:0] att_tot  = HEADROOM_HDB - {5'h00, bst_c, 1'b0}
                          + vol_att + lim_att + {2'b00, sm_att_q};
    wire [3:0] att_k    = 4'(att_tot % 10'd12);
    wire [6:0] att_sh   = 7'(att_tot / 10'd12);
    wire       hard_mute = (vol_code == 8'h00) | (att_sh > 7'd26);

    // Gain multiply and saturate
    // Twelve half-dB steps are 6 dB, a shade less than one octave: trim
    // the mantissa linearly per octave, exact at the headroom octave so
    // that unity gain stays bit exact
    wire [14:0]        corr   = 15'(15'd16306 + 15'd39 * {8'h00, att_sh});
    wire [29:0]        eff_w  = mant(att_k) * corr;
    wire [14:0]        eff    = eff_w[28:14];
    wire signed [39:0] prod   = $signed(SAMPLE_I.data)
                                * $signed({1'b0, eff});
    wire signed [39:0] scaled = (prod >>> 12) >>> att_sh;
    wire               pos_ov = !scaled[39] & (|scaled[38:23]);
    wire               neg_ov = scaled[39] & !(&scaled[38:23]);
    wire [23:0]        sat    = pos_ov ? 24'h7f_ffff :
                                neg_ov ? 24'h80_0000 : scaled[23:0];
    wire [23:0]        gained = hard_mute ? 24'h00_0000 : sat;
    wire [23:0]        negd   = (gained == 24'h80_0000) ? 24'h7f_ffff
                                                        : 24'(-gained);
    wire [23:0]        pol_out = pol_inv ? negd : gained;
    wire [23:0]        mag     = gained[23] ? negd : gained;

    // Level classification for the limiter
    wire               above   = mag > thr_up;
    wire               below   = mag < thr_lo;
    dpg_lim_state_type lim_next;
    assign lim_next = !lim_en ? LIM_HOLD :
                      above   ? LIM_ATTACK :
                      below   ? LIM_DECAY : LIM_HOLD;

    wire sample_go = SAMPLE_I.valid & conv_en;
    wire is_zero   = SAMPLE_I.data == 24'h00_0000;
    wire [10:0] zero_cnt_d =
        !is_zero ? 11'h000 :
        (zero_cnt_q == 11'(ZERO_RUN_LEN)) ? zero_cnt_q
                                          : zero_cnt_q + 11'h001;

    // APB slave: one wait state, answer registered
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc_phase & !pready_q;
            pslverr_q <= acc_phase & !pready_q & !mapped;
            if (acc_phase & !pready_q & !PWRITE_I) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // Control registers
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            power3_q  <= RST_POWER3;
            pb_ctrl_q <= RST_PB_CTRL;
            pb_vol_q  <= RST_PB_VOL;
            lim1_q    <= RST_LIM_CTL1;
            lim2_q    <= RST_LIM_CTL2;
        end else if (wr_ok) begin
            if (hit_pw3) begin
                power3_q <= PWDATA_I[REG_W-1:0];
            end
            if (hit_ctl) begin
                pb_ctrl_q <= PWDATA_I[REG_W-1:0];
            end
            if (hit_vol) begin
                pb_vol_q <= PWDATA_I[REG_W-1:0];
            end
            if (hit_l1) begin
                lim1_q <= PWDATA_I[REG_W-1:0];
            end
            if (hit_l2) begin
                lim2_q <= PWDATA_I[REG_W-1:0];
            end
        end
    end

    // Soft mute ramp, one half-dB step per accepted sample
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sm_att_q <= 8'h00;
        end else if (sample_go) begin
            if (soft_mute && sm_att_q != SM_ATT_MAX) begin
                sm_att_q <= sm_att_q + 8'h01;
            end else if (!soft_mute && sm_att_q != 8'h00) begin
                sm_att_q <= sm_att_q - 8'h01;
            end
        end
    end

    // Limiter gain: samples feed the rate accumulator, clocks drain it
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            lim_state_q <= LIM_HOLD;
            lim_att_q   <= 8'h00;
            acc_q       <= 22'h00_0000;
        end else if (!lim_en) begin
            lim_state_q <= LIM_HOLD;
            lim_att_q   <= 8'h00;
            acc_q       <= 22'h00_0000;
        end else if (sample_go) begin
            lim_state_q <= lim_next;
            acc_q <= ((lim_next == lim_state_q) ? acc_q : 22'h00_0000)
                     + ((lim_next == LIM_HOLD) ? 22'h00_0000 : ACC_ADD);
        end else begin
            case (lim_state_q)
                LIM_ATTACK: begin
                    if (lim_att_q == LIM_ATT_MAX) begin
                        acc_q <= 22'h00_0000;
                    end else if (acc_q >= atk_period) begin
                        lim_att_q <= lim_att_q + 8'h01;
                        acc_q     <= acc_q - atk_period;
                    end
                end
                LIM_DECAY: begin
                    if (lim_att_q == 8'h00) begin
                        acc_q <= 22'h00_0000;
                    end else if (acc_q >= dcy_period) begin
                        lim_att_q <= lim_att_q - 8'h01;
                        acc_q     <= acc_q - dcy_period;
                    end
                end
                LIM_HOLD: begin
                    acc_q <= 22'h00_0000;
                end
                default: begin
                    lim_state_q <= LIM_HOLD;
                end
            endcase
        end
    end

    // Zero-run detector
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            zero_cnt_q  <= 11'h000;
            zero_mute_q <= 1'b0;
        end else if (!conv_en) begin
            zero_cnt_q  <= 11'h000;
            zero_mute_q <= 1'b0;
        end else if (sample_go) begin
            zero_cnt_q  <= zero_cnt_d;
            zero_mute_q <= zmute_en
                           & (zero_cnt_d == 11'(ZERO_RUN_LEN));
        end else if (!zmute_en) begin
            zero_mute_q <= 1'b0;
        end
    end

    // Output sample register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            out_q <= '0;
        end else begin
            out_q.valid <= sample_go;
            if (sample_go) begin
                out_q.data <= pol_out;
            end else if (!conv_en) begin
                out_q.data <= 24'h00_0000;
            end
        end
    end

    assign PRDATA_O    = prdata_q;
    assign PREADY_O    = pready_q;
    assign PSLVERR_O   = pslverr_q;
    assign SAMPLE_O    = out_q;
    assign ZERO_MUTE_O = zero_mute_q;

endmodule : dpg_playback

/* bench/dpg_playback_chk.sv */
// Port-level checks for the playback gain path.
// Assumes a bind onto every dpg_playback instance.
`timescale 1ns/1ps
module dpg_playback_chk
    import dpg_pkg::*;
(
    input wire logic           CLK_I,
    input wire logic           RST_N_I,
    input wire logic           PSEL_I,
    input wire logic           PENABLE_I,
    input wire logic           PWRITE_I,
    input wire logic [9:0]     PADDR_I,
    input wire logic [31:0]    PWDATA_I,
    input wire logic [31:0]    PRDATA_O,
    input wire logic           PREADY_O,
    input wire logic           PSLVERR_O,
    input wire dpg_sample_type SAMPLE_I,
    input wire dpg_sample_type SAMPLE_O,
    input wire logic           ZERO_MUTE_O
);
    logic [10:0] zrun_q;
    logic [10:0] zrun_d;

    // Run of zero input samples, saturating
    assign zrun_d = !SAMPLE_I.valid ? zrun_q
                  : (SAMPLE_I.data != '0) ? 11'h000
                  : (zrun_q == 11'h7ff) ? zrun_q : zrun_q + 11'h001;

    always_ff @(posedge CLK_I) begin
        zrun_q <= RST_N_I ? zrun_d : 11'h000;
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_ready_wait: assert property (PSEL_I && !PENABLE_I |=>
        !PREADY_O ##1 PREADY_O) else $error("ready not after one wait");
    chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    chk_ready_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access phase");
    chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    chk_err_read_zero: assert property (PREADY_O && PSLVERR_O && !PWRITE_I
        |-> PRDATA_O == 32'h0000_0000) else $error("refused read not zero");
    chk_rdata_hold: assert property ($changed(PRDATA_O) |->
        PREADY_O && !PWRITE_I) else $error("read data moved");
    chk_sample_latency: assert property (SAMPLE_O.valid |->
        $past(SAMPLE_I.valid)) else $error("output without input");
    chk_out_pulse: assert property (SAMPLE_O.valid |=> !SAMPLE_O.valid)
        else $error("output valid too long");
    chk_zero_mute_count: assert property ($rose(ZERO_MUTE_O) |->
        SAMPLE_O.valid && zrun_q >= 11'(ZERO_RUN_LEN))
        else $error("zero mute too early");
    chk_zero_mute_drop: assert property (SAMPLE_O.valid &&
        SAMPLE_O.data != '0 |-> !ZERO_MUTE_O)
        else $error("mute held on nonzero output");

    cover property ($rose(ZERO_MUTE_O));
    cover property (PREADY_O && PSLVERR_O);
    cover property (SAMPLE_O.valid && SAMPLE_O.data != '0);
endmodule : dpg_playback_chk

/* bench/dpg_sample_src.sv */
// Stand-in for the audio interface that hands over playback samples.
// Assumes the bench raises go_i for one cycle per sample.
`timescale 1ns/1ps
module dpg_sample_src
    import dpg_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                go_i,
    input  wire logic [SAMPLE_W-1:0] data_i,
    output dpg_sample_type           sample_o
);
    logic fire;

    // Never two samples on adjacent cycles
    assign fire = go_i && !sample_o.valid;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sample_o <= '0;
        end else begin
            sample_o.valid <= fire;
            // Idle data toggles so a stale value is never trusted
            sample_o.data <= fire ? data_i : ~sample_o.data;
        end
    end
endmodule : dpg_sample_src

/* bench/tb.sv */
// Self-checking bench for the playback gain path.
// Assumes the sample source model and the checker in bench/.
`timescale 1ns/1ps
module tb import dpg_pkg::*; ;
    localparam real FS = 8388607.0;
    logic           clk, rst_n, psel, pen, pwr, go, perr, pready, zmute, err;
    logic [9:0]     paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [23:0]    din, got, d;
    logic [7:0]     v;
    dpg_sample_type s_in, s_out;
    int             num_errors, num_checks, got_n, seed, i, n;
    logic [7:0]     idx_t [5];
    logic [8:0]     rst_t [5];

    dpg_sample_src i_src (.clk_i(clk), .rst_n_i(rst_n), .go_i(go),
        .data_i(din), .sample_o(s_in));
    dpg_playback i_dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .SAMPLE_I(s_in), .SAMPLE_O(s_out), .ZERO_MUTE_O(zmute));

    always @(posedge clk) begin
        if (s_out.valid === 1'b1) begin
            got = s_out.data;
            got_n++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic real ex(input logic [23:0] x, input int hdb);
        return $itor($signed(x)) * 10.0 ** (hdb / 40.0);
    endfunction : ex

    function automatic logic near(input logic [23:0] x, input real e);
        real df;
        df = $itor($signed(x)) - e;
        return df * df <= (e * e / 1.0e4) + 4.0 + 4.0 * (e < 0 ? -e : e) / 100;
    endfunction : near

    function automatic logic [23:0] rnd();
        logic [31:0] r;
        r = $random(seed);
        return {{4{r[19]}}, r[19:0]};
    endfunction : rnd

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = perr;
        if (n >= 20) num_errors++;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic send(input logic [23:0] x);
        @(posedge clk);
        go <= 1'b1;
        din <= x;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #1000000;
        num_errors++;
        finish_test();
    end

    initial begin
        {rst_n, psel, pen, pwr, go, paddr, pwdata, din} = '0;
        seed = 10066;
        idx_t = '{IDX_POWER3, IDX_PB_CTRL, IDX_PB_VOL, IDX_LIM_CTL1,
                  IDX_LIM_CTL2};
        rst_t = '{RST_POWER3, RST_PB_CTRL, RST_PB_VOL, RST_LIM_CTL1,
                  RST_LIM_CTL2};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, idx_t[i], '0);
            check(rd, {23'h0, rst_t[i]});
        end
        apb(1'b0, 8'h05, '0);
        check({rd[31:1], rd[0] | ~err}, 32'h0000_0000);
        send(24'h00_1234);
        check(got_n, 0);
        apb(1'b1, IDX_POWER3, 32'h1 << POS_CONV_EN);
        for (i = 0; i < 14; i++) begin
            v = (i < 2) ? 8'(i) : 8'($random(seed));
            d = rnd();
            apb(1'b1, IDX_PB_VOL, {24'h0, v});
            apb(1'b0, IDX_PB_VOL, '0);
            check(rd, {24'h0, v});
            send(d);
            if (v == 8'h00)
                check(got, 0);
            else
                check(near(got, ex(d, int'(v) - 255)), 1);
        end
        apb(1'b1, IDX_PB_VOL, 32'h0000_00ff);
        for (i = 0; i < 13; i++) begin
            d = rnd();
            apb(1'b1, IDX_LIM_CTL2, i << POS_BOOST_LSB);
            send(d);
            if (i == 0)
                check(got, d);
            else
                check(near(got, ex(d, 2 * i)), 1);
        end
        apb(1'b1, IDX_LIM_CTL2, '0);
        apb(1'b1, IDX_PB_CTRL, 32'h1 << POS_POL_INV);
        d = rnd();
        send(d);
        check(got, 24'(-d));
        apb(1'b1, IDX_PB_CTRL, 32'h1 << POS_SOFT_MUTE);
        repeat (2) send(24'h20_0000);
        check(got > 24'h10_0000, 1);
        repeat (270) send(24'h20_0000);
        check(got < 24'h00_0002, 1);
        apb(1'b1, IDX_PB_CTRL, '0);
        repeat (2) send(24'h20_0000);
        check(got < 24'h10_0000, 1);
        repeat (270) send(24'h20_0000);
        check(got, 24'h20_0000);
        apb(1'b1, IDX_PB_CTRL, 32'h1 << POS_ZMUTE_EN);
        send(24'h00_0100);
        repeat (1023) send(24'h00_0000);
        check(zmute, 0);
        send(24'h00_0000);
        check(zmute, 1);
        send(24'h00_0100);
        check(zmute, 0);
        apb(1'b1, IDX_PB_CTRL, '0);
        apb(1'b1, IDX_LIM_CTL1, (32'h1 << POS_LIM_EN) | 32'h3);
        repeat (60) send(24'h7f_0000);
        check($itor(got) < FS * 10.0 ** (-0.025), 1);
        check($itor(got) > FS * 10.0 ** (-0.075), 1);
        repeat (100) send(24'h10_0000);
        check(got, 24'h10_0000);
        apb(1'b1, IDX_LIM_CTL2, 32'h7 << POS_LVL_LSB);
        repeat (60) send(24'h7f_0000);
        check($itor(got) < FS * 10.0 ** (-0.275), 1);
        check($itor(got) > FS * 10.0 ** (-0.325), 1);
        apb(1'b0, IDX_STATUS, '0);
        check(rd[3:0], 4'h2);
        finish_test();
    end
endmodule : tb

bind dpg_playback dpg_playback_chk i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SAMPLE_I(SAMPLE_I),
    .SAMPLE_O(SAMPLE_O), .ZERO_MUTE_O(ZERO_MUTE_O));
